// *** core/ppi_pkg.sv ***
package ppi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer word layout and patterns
  localparam int FLAG_MSB = 15;
  localparam int FLAG_LSB = 12;
  localparam int SS_MSB = 11;
  localparam int SS_LSB = 10;
  localparam int VAL_MSB = 9;
  localparam logic [3:0] FLAG_NORMAL = 4'h6;
  localparam logic [3:0] FLAG_NDF = 4'h9;
  localparam logic [1:0] SS_SDH = 2'h2;
  localparam logic [15:0] AIS_WORD = 16'hFFFF;
  localparam logic [9:0] CONC_VALUE = 10'h3FF;
  localparam logic [9:0] PTR_MAX = 10'h30E;
  localparam logic [9:0] PTR_ZERO = 10'h000;
  localparam logic [9:0] PTR_ONE = 10'h001;
  // I bits at odd positions, D bits at even positions
  localparam logic [9:0] I_MASK = 10'h2AA;
  localparam logic [9:0] D_MASK = 10'h155;

  ////////////////////////////////////////////////////////////////////////////
  // Majority thresholds and frame persistence
  localparam logic [3:0] FLAG_ERR_MAX = 4'h1;
  localparam logic [3:0] SONET_ERR_MAX = 4'h2;
  localparam logic [3:0] SDH_MAJOR_MIN = 4'h3;
  localparam logic [3:0] SDH_MINOR_MAX = 4'h2;
  localparam logic [1:0] HOLD_FRAMES = 2'h3;
  localparam logic [1:0] STATE_NORMAL_PERSIST = 2'h3;
  localparam logic [1:0] AIS_PERSIST = 2'h3;
  localparam logic [3:0] LOP_PERSIST = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and fields
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
  localparam logic [31:0] ADDR_PEND = 32'h0000_0008;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_SDH_BIT = 0;
  localparam int CTRL_ALARM_A_BIT = 4;
  localparam int CTRL_ALARM_B_BIT = 5;
  localparam int CTRL_LOSS_A_BIT = 6;
  localparam int CTRL_LOSS_B_BIT = 7;
  localparam int STAT_ALARM_BIT = 2;
  localparam int STAT_LOSS_BIT = 3;
  localparam int STAT_ALARM_LATCH_BIT = 4;
  localparam int STAT_LOSS_LATCH_BIT = 5;
  localparam int STAT_PTR_LSB = 16;
  localparam int PEND_ALARM_BIT = 0;
  localparam int PEND_LOSS_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    state_normal = 2'b00,
    state_pointer_lost = 2'b01,
    state_alarm_ind = 2'b10
  } ppi_state_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } ppi_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ppi_axi_rsp_t;

  typedef struct packed {
    ppi_state_t state;
    logic [9:0] ptr;
    logic [9:0] cand;
    logic [1:0] cand_cnt;
    logic [1:0] ais_cnt;
    logic [3:0] inv_cnt;
    logic [1:0] hold;
    logic [15:0] word;
    logic word_seen;
    logic conc_bad;
    logic [7:0] ctrl;
    logic lat_ais;
    logic lat_lop;
    logic pend_ais;
    logic pend_lop;
    logic irq_a;
    logic irq_b;
    logic aw_have;
    logic [31:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    ppi_axi_rsp_t rsp;
  } ppi_regs_t;

endpackage

// *** core/ppi_pointer_interp.sv ***
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Normal flag with current pointer, I bits inverted, means increment.
// - Normal flag with current pointer, D bits inverted, means decrement.
// - Normal: 3 of 4 flag bits 0110, value 0..782, SS checked in SDH.
// - New data flag: 3 of 4 flag bits 1001, value in range, SS as normal.
// - AIS pointer is the all-ones sixteen bit word.
// - Secondary words must be normal concatenation or all-ones, else invalid.
// - No justification for three frames after justification or new data flag.
// - SONET increment: at least 8 of 10 bits match D kept, I inverted.
// - SONET decrement: at least 8 of 10 bits match I kept, D inverted.
// - SDH increment: 3 or more I inverted, 2 or fewer D inverted.
// - SDH decrement: 3 or more D inverted, 2 or fewer I inverted.
// - SDH: 3 or more of both inverted gives no justification.
// - Three state machine: normal, pointer lost, alarm indication.
// - In normal, one valid new data flag adopts its value, stays normal.
// - Three equal valid normal pointers from any state enter normal.
// - Eight invalid pointers from normal or alarm enter pointer lost.
// - One valid justification word adjusts the pointer at once.
// - In alarm state only the AIS pointer counts as valid.
// - In normal, a normal pointer equal to current also counts valid.
// - Alarm state change sets latch-high and pending bits, two masked IRQs.
// - Loss state change sets latch-high and pending bits, two masked IRQs.
// - Flag bits 15:12, SS 11:10, value 9:0 with I at odd bits.
// - SDH mode compares SS with 10, mismatch is invalid.
// - Configuration bit selects SONET or SDH interpretation.
// - Ten bit value is payload offset after H3.
module ppi_pointer_interp (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic frame_aligned_i,
  input wire logic ptr_strobe_i,
  input wire logic [15:0] ptr_word_i,
  input wire logic conc_strobe_i,
  input wire logic [15:0] conc_word_i,
  input wire logic frame_done_i,
  input wire ppi_pkg::ppi_axi_req_t axi_req_i,
  output ppi_pkg::ppi_axi_rsp_t axi_rsp_o,
  output logic irq_out_a_o,
  output logic irq_out_b_o
);

  // Ones count over a ten bit field
  function automatic logic [3:0] ppi_ones(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 10; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  ppi_pkg::ppi_regs_t r_reg;
  ppi_pkg::ppi_regs_t r_next;

  logic eval;
  logic sdh;
  logic [9:0] val;
  logic ss_ok;
  logic in_range;
  logic is_ais;
  logic flag_state_normal;
  logic flag_ndf;
  logic clean;
  logic ndf_ok;
  logic state_normal_ok;
  logic [3:0] inc_err;
  logic [3:0] dec_err;
  logic [3:0] inv_i;
  logic [3:0] inv_d;
  logic inc_hit;
  logic dec_hit;
  logic jus_ok;
  logic do_inc;
  logic do_dec;
  logic valid_state_normal;
  logic invalid;
  logic conc_ok;
  logic ais_chg;
  logic lop_chg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  logic rd_stat;
  logic rd_pend;

  //////////////////////////////////////////////////////////////////////////////
  // Pointer word classification
  always_comb begin
    eval = frame_done_i && frame_aligned_i;
    sdh = r_reg.ctrl[ppi_pkg::CTRL_SDH_BIT];
    val = r_reg.word[ppi_pkg::VAL_MSB:0];
    ss_ok = !sdh || (r_reg.word[ppi_pkg::SS_MSB:ppi_pkg::SS_LSB] == ppi_pkg::SS_SDH);
    in_range = val <= ppi_pkg::PTR_MAX;
    is_ais = r_reg.word == ppi_pkg::AIS_WORD;
    flag_state_normal = ppi_ones({6'h00, r_reg.word[ppi_pkg::FLAG_MSB:ppi_pkg::FLAG_LSB] ^ ppi_pkg::FLAG_NORMAL})
                <= ppi_pkg::FLAG_ERR_MAX;
    flag_ndf = ppi_ones({6'h00, r_reg.word[ppi_pkg::FLAG_MSB:ppi_pkg::FLAG_LSB] ^ ppi_pkg::FLAG_NDF})
               <= ppi_pkg::FLAG_ERR_MAX;
    // A missing primary word or a bad secondary pair spoils the frame
    clean = r_reg.word_seen && !r_reg.conc_bad;
    ndf_ok = clean && flag_ndf && in_range && ss_ok;
    state_normal_ok = clean && flag_state_normal && in_range && ss_ok;
    // Distance to the two justification patterns
    inc_err = ppi_ones(val ^ (r_reg.ptr ^ ppi_pkg::I_MASK));
    dec_err = ppi_ones(val ^ (r_reg.ptr ^ ppi_pkg::D_MASK));
    inv_i = ppi_ones((val ^ r_reg.ptr) & ppi_pkg::I_MASK);
    inv_d = ppi_ones((val ^ r_reg.ptr) & ppi_pkg::D_MASK);
    if (sdh) begin
      inc_hit = (inv_i >= ppi_pkg::SDH_MAJOR_MIN) && (inv_d <= ppi_pkg::SDH_MINOR_MAX);
      dec_hit = (inv_d >= ppi_pkg::SDH_MAJOR_MIN) && (inv_i <= ppi_pkg::SDH_MINOR_MAX);
    end else begin
      inc_hit = inc_err <= ppi_pkg::SONET_ERR_MAX;
      dec_hit = dec_err <= ppi_pkg::SONET_ERR_MAX;
    end
    // Range is not checked: an inverted pattern may exceed 782 numerically
    jus_ok = eval && clean && flag_state_normal && ss_ok && (r_reg.state == ppi_pkg::state_normal)
             && (r_reg.hold == 2'h0);
    do_inc = jus_ok && inc_hit;
    do_dec = jus_ok && dec_hit && !inc_hit;
    valid_state_normal = ndf_ok || (state_normal_ok && (val == r_reg.ptr)) || do_inc || do_dec;
    invalid = (r_reg.state == ppi_pkg::state_alarm_ind) ? !is_ais : !valid_state_normal;
    // Secondary pair check on the live word
    conc_ok = (conc_word_i == ppi_pkg::AIS_WORD)
              || ((ppi_ones({6'h00, conc_word_i[ppi_pkg::FLAG_MSB:ppi_pkg::FLAG_LSB] ^ ppi_pkg::FLAG_NORMAL})
                   <= ppi_pkg::FLAG_ERR_MAX)
                  && (conc_word_i[ppi_pkg::VAL_MSB:0] == ppi_pkg::CONC_VALUE)
                  && (!sdh || (conc_word_i[ppi_pkg::SS_MSB:ppi_pkg::SS_LSB] == ppi_pkg::SS_SDH)));
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state: frame decision, alarms, bus slave
  always_comb begin
    r_next = r_reg;
    aw_take = axi_req_i.awvalid && r_reg.rsp.awready;
    w_take = axi_req_i.wvalid && r_reg.rsp.wready;
    ar_take = axi_req_i.arvalid && r_reg.rsp.arready;
    wr_go = r_reg.aw_have && r_reg.w_have && !r_reg.rsp.bvalid;
    rd_stat = ar_take && (axi_req_i.araddr == ppi_pkg::ADDR_STAT);
    rd_pend = ar_take && (axi_req_i.araddr == ppi_pkg::ADDR_PEND);

    // Per-frame interpretation
    if (eval) begin
      r_next.word_seen = 1'b0;
      r_next.conc_bad = 1'b0;
      r_next.hold = (r_reg.hold != 2'h0) ? r_reg.hold - 2'h1 : 2'h0;
      r_next.ais_cnt = is_ais ? ((r_reg.ais_cnt == ppi_pkg::AIS_PERSIST) ? r_reg.ais_cnt
                                 : r_reg.ais_cnt + 2'h1) : 2'h0;
      r_next.inv_cnt = invalid ? ((r_reg.inv_cnt == ppi_pkg::LOP_PERSIST) ? r_reg.inv_cnt
                                  : r_reg.inv_cnt + 4'h1) : 4'h0;
      if (state_normal_ok && (val == r_reg.cand)) begin
        r_next.cand_cnt = (r_reg.cand_cnt == ppi_pkg::STATE_NORMAL_PERSIST) ? r_reg.cand_cnt
                          : r_reg.cand_cnt + 2'h1;
      end else if (state_normal_ok) begin
        r_next.cand = val;
        r_next.cand_cnt = 2'h1;
      end else begin
        r_next.cand_cnt = 2'h0;
      end
      // Pointer moves inside normal state
      if ((r_reg.state == ppi_pkg::state_normal) && ndf_ok) begin
        r_next.ptr = val;
        r_next.hold = ppi_pkg::HOLD_FRAMES;
      end else if (do_inc) begin
        r_next.ptr = (r_reg.ptr == ppi_pkg::PTR_MAX) ? ppi_pkg::PTR_ZERO : r_reg.ptr + ppi_pkg::PTR_ONE;
        r_next.hold = ppi_pkg::HOLD_FRAMES;
      end else if (do_dec) begin
        r_next.ptr = (r_reg.ptr == ppi_pkg::PTR_ZERO) ? ppi_pkg::PTR_MAX : r_reg.ptr - ppi_pkg::PTR_ONE;
        r_next.hold = ppi_pkg::HOLD_FRAMES;
      end
      // State transitions, AIS and invalid counters restart on entry
      case (r_reg.state)
        ppi_pkg::state_normal,
        ppi_pkg::state_pointer_lost,
        ppi_pkg::state_alarm_ind: begin
          if (r_next.cand_cnt == ppi_pkg::STATE_NORMAL_PERSIST && state_normal_ok && !((r_reg.state == ppi_pkg::state_normal)
              && (ndf_ok || do_inc || do_dec))) begin
            r_next.state = ppi_pkg::state_normal;
            r_next.ptr = val;
          end else if ((r_next.ais_cnt == ppi_pkg::AIS_PERSIST) && (r_reg.state != ppi_pkg::state_alarm_ind)) begin
            r_next.state = ppi_pkg::state_alarm_ind;
          end else if ((r_next.inv_cnt == ppi_pkg::LOP_PERSIST) && (r_reg.state != ppi_pkg::state_pointer_lost)) begin
            r_next.state = ppi_pkg::state_pointer_lost;
          end
        end
        default: begin
          r_next.state = ppi_pkg::state_pointer_lost;
        end
      endcase
      if (r_next.state != r_reg.state) begin
        r_next.ais_cnt = 2'h0;
        r_next.inv_cnt = 4'h0;
      end
    end

    // Word capture after the frame clear, so a new word is never lost
    if (ptr_strobe_i) begin
      r_next.word = ptr_word_i;
      r_next.word_seen = 1'b1;
    end
    if (conc_strobe_i && !conc_ok) begin
      r_next.conc_bad = 1'b1;
    end

    // Alarm events: set wins over read clear
    ais_chg = (r_next.state == ppi_pkg::state_alarm_ind) != (r_reg.state == ppi_pkg::state_alarm_ind);
    lop_chg = (r_next.state == ppi_pkg::state_pointer_lost) != (r_reg.state == ppi_pkg::state_pointer_lost);
    if (rd_stat) begin
      // After a read the latch falls back to the live status
      r_next.lat_ais = (r_reg.state == ppi_pkg::state_alarm_ind) || ais_chg;
      r_next.lat_lop = (r_reg.state == ppi_pkg::state_pointer_lost) || lop_chg;
    end else begin
      r_next.lat_ais = r_reg.lat_ais || ais_chg;
      r_next.lat_lop = r_reg.lat_lop || lop_chg;
    end
    r_next.pend_ais = (r_reg.pend_ais && !rd_pend) || ais_chg;
    r_next.pend_lop = (r_reg.pend_lop && !rd_pend) || lop_chg;
    r_next.irq_a = (r_reg.pend_ais && r_reg.ctrl[ppi_pkg::CTRL_ALARM_A_BIT])
                   || (r_reg.pend_lop && r_reg.ctrl[ppi_pkg::CTRL_LOSS_A_BIT]);
    r_next.irq_b = (r_reg.pend_ais && r_reg.ctrl[ppi_pkg::CTRL_ALARM_B_BIT])
                   || (r_reg.pend_lop && r_reg.ctrl[ppi_pkg::CTRL_LOSS_B_BIT]);

    // Write channels: address and data held until both are present
    if (aw_take) begin
      r_next.aw_have = 1'b1;
      r_next.aw_addr = axi_req_i.awaddr;
    end
    if (w_take) begin
      r_next.w_have = 1'b1;
      r_next.wdata = axi_req_i.wdata;
      r_next.wstrb = axi_req_i.wstrb;
    end
    if (r_reg.rsp.bvalid && axi_req_i.bready) begin
      r_next.rsp.bvalid = 1'b0;
    end
    if (wr_go) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.rsp.bvalid = 1'b1;
      if (r_reg.aw_addr == ppi_pkg::ADDR_CTRL) begin
        r_next.rsp.bresp = ppi_pkg::RESP_OKAY;
        if (r_reg.wstrb[0]) begin
          r_next.ctrl = r_reg.wdata[7:0];
        end
      end else begin
        // Status words are read only; a write there is refused
        r_next.rsp.bresp = ppi_pkg::RESP_SLVERR;
      end
    end

    // Read channel
    if (r_reg.rsp.rvalid && axi_req_i.rready) begin
      r_next.rsp.rvalid = 1'b0;
    end
    if (ar_take) begin
      r_next.rsp.rvalid = 1'b1;
      r_next.rsp.rdata = 32'h0000_0000;
      r_next.rsp.rresp = ppi_pkg::RESP_OKAY;
      case (axi_req_i.araddr)
        ppi_pkg::ADDR_CTRL: begin
          r_next.rsp.rdata[7:0] = r_reg.ctrl;
        end
        ppi_pkg::ADDR_STAT: begin
          r_next.rsp.rdata[1:0] = r_reg.state;
          r_next.rsp.rdata[ppi_pkg::STAT_ALARM_BIT] = r_reg.state == ppi_pkg::state_alarm_ind;
          r_next.rsp.rdata[ppi_pkg::STAT_LOSS_BIT] = r_reg.state == ppi_pkg::state_pointer_lost;
          r_next.rsp.rdata[ppi_pkg::STAT_ALARM_LATCH_BIT] = r_reg.lat_ais;
          r_next.rsp.rdata[ppi_pkg::STAT_LOSS_LATCH_BIT] = r_reg.lat_lop;
          r_next.rsp.rdata[ppi_pkg::STAT_PTR_LSB +: 10] = r_reg.ptr;
        end
        ppi_pkg::ADDR_PEND: begin
          r_next.rsp.rdata[ppi_pkg::PEND_ALARM_BIT] = r_reg.pend_ais;
          r_next.rsp.rdata[ppi_pkg::PEND_LOSS_BIT] = r_reg.pend_lop;
        end
        default: begin
          r_next.rsp.rresp = ppi_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Ready flags computed from what will be held next cycle
    r_next.rsp.awready = !r_next.aw_have && !r_next.rsp.bvalid;
    r_next.rsp.wready = !r_next.w_have && !r_next.rsp.bvalid;
    r_next.rsp.arready = !r_next.rsp.rvalid;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register, pointer lost after reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
      r_reg.state <= ppi_pkg::state_pointer_lost;
      r_reg.ctrl <= ppi_pkg::CTRL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign axi_rsp_o = r_reg.rsp;
  assign irq_out_a_o = r_reg.irq_a;
  assign irq_out_b_o = r_reg.irq_b;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_hold_blocks_jus: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (r_reg.hold != 2'h0) |-> !do_inc && !do_dec)
    else $error("justification accepted inside hold window");

  a_inc_wraps_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    do_inc |=> (r_reg.ptr == (($past(r_reg.ptr) == ppi_pkg::PTR_MAX) ? ppi_pkg::PTR_ZERO
                              : $past(r_reg.ptr) + ppi_pkg::PTR_ONE)) && (r_reg.hold == ppi_pkg::HOLD_FRAMES))
    else $error("increment did not step or wrap the pointer");

  a_ndf_adopts_val: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (eval && ndf_ok && r_reg.state == ppi_pkg::state_normal)
    |=> (r_reg.ptr == $past(val)) && (r_reg.state == ppi_pkg::state_normal))
    else $error("new data flag not adopted in normal state");

  a_ais_entry_three: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (eval && is_ais && r_reg.ais_cnt == 2'h2 && r_reg.state != ppi_pkg::state_alarm_ind && !state_normal_ok)
    |=> r_reg.state == ppi_pkg::state_alarm_ind)
    else $error("third AIS pointer did not enter alarm state");

  a_lop_entry_eight: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (eval && invalid && r_reg.inv_cnt == 4'h7 && r_reg.state != ppi_pkg::state_pointer_lost && !state_normal_ok && !is_ais)
    |=> r_reg.state == ppi_pkg::state_pointer_lost)
    else $error("eighth invalid pointer did not enter loss state");

  a_state_normal_entry_three: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (eval && state_normal_ok && val == r_reg.cand && r_reg.cand_cnt == 2'h2 && r_reg.state != ppi_pkg::state_normal)
    |=> (r_reg.state == ppi_pkg::state_normal) && (r_reg.ptr == $past(val)))
    else $error("three equal pointers did not enter normal state");

  a_sdh_both_none: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (sdh && inv_i >= 4'h3 && inv_d >= 4'h3) |-> !do_inc && !do_dec)
    else $error("justification taken with both halves inverted");

  a_alarm_only_ais: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (eval && r_reg.state == ppi_pkg::state_alarm_ind && !is_ais && r_reg.inv_cnt != ppi_pkg::LOP_PERSIST)
    |=> (r_reg.state != ppi_pkg::state_alarm_ind) || (r_reg.inv_cnt == $past(r_reg.inv_cnt) + 4'h1))
    else $error("non AIS word counted valid in alarm state");

  a_alarm_change_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(r_reg.state == ppi_pkg::state_alarm_ind) |-> r_reg.pend_ais && r_reg.lat_ais
    ##1 (r_reg.irq_a || !$past(r_reg.ctrl[ppi_pkg::CTRL_ALARM_A_BIT])))
    else $error("alarm state change not flagged");

  a_loss_change_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(r_reg.state == ppi_pkg::state_pointer_lost) |-> r_reg.pend_lop && r_reg.lat_lop)
    else $error("loss state change not flagged");

  a_sonet_inc_match: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!sdh && do_inc) |-> (inc_err <= 4'h2) ##1 (r_reg.hold == 2'h3))
    else $error("SONET increment without eight matching bits");

  a_dec_steps_down: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    do_dec |=> r_reg.ptr == (($past(r_reg.ptr) == ppi_pkg::PTR_ZERO) ? ppi_pkg::PTR_MAX
                             : $past(r_reg.ptr) - ppi_pkg::PTR_ONE))
    else $error("decrement did not step or wrap the pointer");

  a_irq_b_alarm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (r_reg.pend_ais && r_reg.ctrl[ppi_pkg::CTRL_ALARM_B_BIT]) |=> r_reg.irq_b)
    else $error("pending alarm with B mask did not raise irq b");

  a_irq_a_loss: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (r_reg.pend_lop && r_reg.ctrl[ppi_pkg::CTRL_LOSS_A_BIT]) |=> r_reg.irq_a)
    else $error("pending loss with A mask did not raise irq a");

  a_pend_read_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_pend && !ais_chg && !lop_chg) |=> !r_reg.pend_ais && !r_reg.pend_lop)
    else $error("pending bits not cleared by read");

  a_ss_gate_sdh: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (sdh && r_reg.word[ppi_pkg::SS_MSB:ppi_pkg::SS_LSB] != ppi_pkg::SS_SDH) |-> !do_inc && !do_dec && !state_normal_ok)
    else $error("SS mismatch accepted in SDH mode");

endmodule

// *** tb/ppi_line_model.sv ***
////////////////////////////////////////////////////////////////////////////
// Remote line side: one primary word, one secondary word, then frame end
module ppi_line_model (
  input wire logic core_clk_i,
  output logic ptr_strobe_o,
  output logic [15:0] ptr_word_o,
  output logic conc_strobe_o,
  output logic [15:0] conc_word_o,
  output logic frame_done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet lines at time zero
  initial begin
    ptr_strobe_o = 1'b0;
    ptr_word_o = 16'h0000;
    conc_strobe_o = 1'b0;
    conc_word_o = 16'h0000;
    frame_done_o = 1'b0;
  end

  // Words are inverted once their strobe drops, so stale data never matches
  task automatic send(input logic [15:0] w, input logic [15:0] c);
    @(posedge core_clk_i);
    ptr_strobe_o <= 1'b1;
    ptr_word_o <= w;
    @(posedge core_clk_i);
    ptr_strobe_o <= 1'b0;
    ptr_word_o <= ~w;
    conc_strobe_o <= 1'b1;
    conc_word_o <= c;
    @(posedge core_clk_i);
    conc_strobe_o <= 1'b0;
    conc_word_o <= ~c;
    frame_done_o <= 1'b1;
    @(posedge core_clk_i);
    frame_done_o <= 1'b0;
  endtask
endmodule

// *** tb/ppi_pointer_interp_test.sv ***
module ppi_pointer_interp_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic frame_aligned_i = 1'b1;
  logic ptr_strobe, conc_strobe, frame_done, irq_a, irq_b;
  logic [15:0] ptr_word, conc_word;
  ppi_pkg::ppi_axi_req_t req = '0;
  ppi_pkg::ppi_axi_rsp_t rsp;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [1:0] rr;

  // 250 MHz clock
  always #2 core_clk_i = ~core_clk_i;

  ppi_line_model ppi_line_model_inst (.core_clk_i(core_clk_i), .ptr_strobe_o(ptr_strobe), .ptr_word_o(ptr_word),
    .conc_strobe_o(conc_strobe), .conc_word_o(conc_word), .frame_done_o(frame_done));
  ppi_pointer_interp ppi_pointer_interp_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .frame_aligned_i(frame_aligned_i), .ptr_strobe_i(ptr_strobe), .ptr_word_i(ptr_word),
    .conc_strobe_i(conc_strobe), .conc_word_i(conc_word), .frame_done_i(frame_done),
    .axi_req_i(req), .axi_rsp_o(rsp), .irq_out_a_o(irq_a), .irq_out_b_o(irq_b));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write: address and data together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    while (aw || w) begin
      @(posedge core_clk_i);
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    req.bready <= 1'b1;
    do @(posedge core_clk_i); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
  endtask

  // Read: rready held high until the answer is sampled
  task automatic rdr(input logic [31:0] a);
    @(posedge core_clk_i);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // State and accepted pointer fields only
  task automatic st(input logic [31:0] e);
    rdr(ppi_pkg::ADDR_STAT);
    chk("stat", e, rd & 32'h03FF0003);
  endtask

  task automatic fr(input logic [15:0] w, input logic [15:0] c, input int n);
    repeat (n) ppi_line_model_inst.send(w, c);
  endtask

  task stop_test;
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: link states, justification, register access
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rdr(ppi_pkg::ADDR_STAT);
    chk("stat_rst", 32'h0000_0009, rd);
    wr(ppi_pkg::ADDR_CTRL, 32'h0000_00F0, ppi_pkg::RESP_OKAY);
    rdr(ppi_pkg::ADDR_CTRL);
    chk("ctrl", 32'h0000_00F0, rd);
    wr(ppi_pkg::ADDR_STAT, 32'h0000_0001, ppi_pkg::RESP_SLVERR);
    rdr(32'h0000_0010);
    chk("unmapped", 32'h0000_0002, {rd[29:0], rr});
    fr(16'h620A, 16'h63FF, 2);
    st(32'h0000_0001);
    fr(16'h620A, 16'h63FF, 1);
    rdr(ppi_pkg::ADDR_STAT);
    chk("stat_state_normal", 32'h020A_0020, rd);
    chk("irq_a", 32'h1, {31'h0, irq_a});
    chk("irq_b", 32'h1, {31'h0, irq_b});
    rdr(ppi_pkg::ADDR_PEND);
    chk("pend", 32'h0000_0002, rd);
    repeat (3) @(posedge core_clk_i);
    chk("irq_clr", 32'h0, {31'h0, irq_a});
    fr(16'h60A0, 16'h63FF, 1);
    st(32'h020B_0000);
    fr(16'h635E, 16'h63FF, 1);
    st(32'h020B_0000);
    fr(16'h620B, 16'h63FF, 2);
    fr(16'h635E, 16'h63FF, 1);
    st(32'h020A_0000);
    fr(16'h9100, 16'h63FF, 1);
    st(32'h0100_0000);
    fr(16'hFFFF, 16'hFFFF, 3);
    st(32'h0100_0002);
    rdr(ppi_pkg::ADDR_PEND);
    chk("pend_ais", 32'h0000_0001, rd);
    fr(16'h0000, 16'h63FF, 7);
    st(32'h0100_0002);
    fr(16'h0000, 16'h63FF, 1);
    st(32'h0100_0001);
    rdr(ppi_pkg::ADDR_PEND);
    chk("pend_lop", 32'h0000_0003, rd);
    wr(ppi_pkg::ADDR_CTRL, 32'h0000_0001, ppi_pkg::RESP_OKAY);
    fr(16'h6A0A, 16'h6BFF, 3);
    st(32'h020A_0000);
    fr(16'h6B5F, 16'h6BFF, 1);
    st(32'h0209_0000);
    fr(16'h6A09, 16'h6BFF, 3);
    fr(16'h69F6, 16'h6BFF, 1);
    st(32'h0209_0000);
    fr(16'h68A3, 16'h6BFF, 1);
    st(32'h020A_0000);
    frame_aligned_i <= 1'b0;
    fr(16'hFFFF, 16'hFFFF, 3);
    st(32'h020A_0000);
    stop_test;
  end

  // Watchdog: the sequence needs about one microsecond
  initial begin
    #20000;
    errors++;
    stop_test;
  end
endmodule
